// *** logic/pioc_regs.vh ***
// register offsets, reset values and sizes of the parallel io controller
`ifndef PIOC_REGS_VH
`define PIOC_REGS_VH
`define PIOC_W 32
`define PIOC_AW 8
`define PIOC_OWN_SET 8'h00
`define PIOC_OWN_CLR 8'h04
`define PIOC_OWN_STATE 8'h08
`define PIOC_DRV_SET 8'h10
`define PIOC_DRV_CLR 8'h14
`define PIOC_DRV_STATE 8'h18
`define PIOC_DGL_SET 8'h20
`define PIOC_DGL_CLR 8'h24
`define PIOC_DGL_STATE 8'h28
`define PIOC_OUT_SET 8'h30
`define PIOC_OUT_CLR 8'h34
`define PIOC_OUT_STATE 8'h38
`define PIOC_PIN_SAMPLE 8'h3c
`define PIOC_IRQ_SET 8'h40
`define PIOC_IRQ_CLR 8'h44
`define PIOC_IRQ_MASK 8'h48
`define PIOC_IRQ_PEND 8'h4c
`define PIOC_OD_SET 8'h50
`define PIOC_OD_CLR 8'h54
`define PIOC_OD_STATE 8'h58
`define PIOC_PU_CLR 8'h60
`define PIOC_PU_SET 8'h64
`define PIOC_PU_STATE 8'h68
`define PIOC_SEL_FIRST 8'h70
`define PIOC_SEL_SECOND 8'h74
`define PIOC_SEL_STATE 8'h78
`define PIOC_DW_SET 8'ha0
`define PIOC_DW_CLR 8'ha4
`define PIOC_DW_STATE 8'ha8
`define PIOC_ZERO 32'h00000000
`define PIOC_ALL 32'hffffffff
`endif

// *** logic/pioc_top.v ***
// parallel io controller: register file, pin muxing and change detection
`timescale 1ns/10ps
`include "pioc_regs.vh"

// Notes on behaviour
// - every register is 32 bits, bit n belongs to line n
// - bits of absent lines ignore writes and read zero
// - lines without peripheral function stay controller-owned, ownership reads one
// - ownership set register writes give lines to the controller
// - ownership clear register writes hand lines to their peripheral
// - ownership state accumulates writes; reset value is a parameter
// - deglitch set and clear update deglitch state
// - out level set and clear registers set and clear output data
// - direct write to output data only on bits enabled for direct write
// - pin level register returns sampled pin levels, no fixed reset
// - change pending resets to zero, may fill right after reset
// - pullup clear and set registers update pullup state
// - first select clears, second select sets the peripheral select state
// - direct write mask set and clear; state resets to zero
// - change irq set and clear update mask; masked lines raise interrupt
// - reading change pending clears all pending bits except lines that change in that same cycle
// - drive state zero is input only, one drives when controller owns line
// - select zero routes peripheral a output, one routes peripheral b
module pioc_top #(
  parameter [31:0] LINE_PRESENT = 32'hffffffff,
  parameter [31:0] LINE_MUXED = 32'hffffffff,
  parameter [31:0] OWN_RESET = 32'h00000000
) (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output reg [31:0] rdata_o,
  // pins
  input wire [31:0] pin_i,
  output wire [31:0] pin_o,
  output wire [31:0] pin_oe_n_o,
  output wire [31:0] pullup_o,
  // peripherals
  input wire [31:0] pa_out_i,
  input wire [31:0] pa_oe_i,
  input wire [31:0] pb_out_i,
  input wire [31:0] pb_oe_i,
  output wire [31:0] periph_in_o,
  // interrupt to downstream controller
  output wire irq_o
);


  // architectural state, bit n of each word belongs to line n
  reg [31:0] own;
  reg [31:0] drv;
  reg [31:0] dgl;
  reg [31:0] outd;
  reg [31:0] imask;
  reg [31:0] pend;
  reg [31:0] od;
  reg [31:0] pu;
  reg [31:0] sel;
  reg [31:0] dw;

  // input sampling chain
  reg [31:0] sync1;
  reg [31:0] sync2;
  reg [31:0] sync3;
  reg [31:0] filt;
  reg [31:0] prev;
  reg prev_ok;

  // next values of the state above
  reg [31:0] next_own;
  reg [31:0] next_drv;
  reg [31:0] next_dgl;
  reg [31:0] next_outd;
  reg [31:0] next_imask;
  reg [31:0] next_pend;
  reg [31:0] next_od;
  reg [31:0] next_pu;
  reg [31:0] next_sel;
  reg [31:0] next_dw;
  reg [31:0] next_filt;
  reg [31:0] next_rdata;

  // combinational views
  wire [31:0] wmask;
  wire [31:0] level;
  wire [31:0] change;
  wire [31:0] steady;
  wire [31:0] own_eff;
  wire [31:0] mux_out;
  wire [31:0] mux_oe;
  wire [31:0] line_out;
  wire [31:0] line_drive;
  wire direct_hit;
  wire pend_read;

  // decoded write data, zero unless that offset is written; direct_d is gated by dw and wmask, not by the offset
  wire [31:0] own_set_d;
  wire [31:0] own_clr_d;
  wire [31:0] drv_set_d;
  wire [31:0] drv_clr_d;
  wire [31:0] dgl_set_d;
  wire [31:0] dgl_clr_d;
  wire [31:0] out_set_d;
  wire [31:0] out_clr_d;
  wire [31:0] irq_set_d;
  wire [31:0] irq_clr_d;
  wire [31:0] od_set_d;
  wire [31:0] od_clr_d;
  wire [31:0] pu_set_d;
  wire [31:0] pu_clr_d;
  wire [31:0] sel_first_d;
  wire [31:0] sel_second_d;
  wire [31:0] dw_set_d;
  wire [31:0] dw_clr_d;
  wire [31:0] direct_d;

  // set-clear helper; set applies after clear, so set wins per line
  function [31:0] setclr;
    input [31:0] cur;
    input [31:0] s;
    input [31:0] c;
    begin
      setclr = (cur & ~c) | s;
    end
  endfunction

  // strobe qualified by one register offset
  function hit;
    input [7:0] a;
    input strobe;
    begin
      hit = strobe && (addr_i == a);
    end
  endfunction

  // write data at one offset, absent lines masked off
  function [31:0] wr_at;
    input [7:0] a;
    begin
      wr_at = hit(a, wr_i) ? (wdata_i & wmask) : `PIOC_ZERO;
    end
  endfunction

  assign wmask = LINE_PRESENT;
  assign direct_hit = hit(`PIOC_OUT_STATE, wr_i);
  assign pend_read = hit(`PIOC_IRQ_PEND, rd_i);

  assign own_set_d = wr_at(`PIOC_OWN_SET);
  assign own_clr_d = wr_at(`PIOC_OWN_CLR);
  assign drv_set_d = wr_at(`PIOC_DRV_SET);
  assign drv_clr_d = wr_at(`PIOC_DRV_CLR);
  assign dgl_set_d = wr_at(`PIOC_DGL_SET);
  assign dgl_clr_d = wr_at(`PIOC_DGL_CLR);
  assign out_set_d = wr_at(`PIOC_OUT_SET);
  assign out_clr_d = wr_at(`PIOC_OUT_CLR);
  assign irq_set_d = wr_at(`PIOC_IRQ_SET);
  assign irq_clr_d = wr_at(`PIOC_IRQ_CLR);
  assign od_set_d = wr_at(`PIOC_OD_SET);
  assign od_clr_d = wr_at(`PIOC_OD_CLR);
  assign pu_set_d = wr_at(`PIOC_PU_SET);
  assign pu_clr_d = wr_at(`PIOC_PU_CLR);
  assign sel_first_d = wr_at(`PIOC_SEL_FIRST);
  assign sel_second_d = wr_at(`PIOC_SEL_SECOND);
  assign dw_set_d = wr_at(`PIOC_DW_SET);
  assign dw_clr_d = wr_at(`PIOC_DW_CLR);
  assign direct_d = wdata_i & dw & wmask;

  // line ownership
  always @* begin
    next_own = setclr(own, own_set_d, own_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      own <= OWN_RESET;
    end else begin
      own <= next_own;
    end
  end

  // drive enable, kept even while a peripheral owns the line
  always @* begin
    next_drv = setclr(drv, drv_set_d, drv_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      drv <= `PIOC_ZERO;
    end else begin
      drv <= next_drv;
    end
  end

  // deglitch enable
  always @* begin
    next_dgl = setclr(dgl, dgl_set_d, dgl_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dgl <= `PIOC_ZERO;
    end else begin
      dgl <= next_dgl;
    end
  end

  // output data; direct write only touches unmasked lines
  always @* begin
    if (direct_hit) begin
      next_outd = (outd & ~(dw & wmask)) | direct_d;
    end else begin
      next_outd = setclr(outd, out_set_d, out_clr_d);
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      outd <= `PIOC_ZERO;
    end else begin
      outd <= next_outd;
    end
  end

  // change interrupt mask
  always @* begin
    next_imask = setclr(imask, irq_set_d, irq_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      imask <= `PIOC_ZERO;
    end else begin
      imask <= next_imask;
    end
  end

  // open drain enable
  always @* begin
    next_od = setclr(od, od_set_d, od_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      od <= `PIOC_ZERO;
    end else begin
      od <= next_od;
    end
  end

  // pull-up enable; clear sits at the lower offset here
  always @* begin
    next_pu = setclr(pu, pu_set_d, pu_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pu <= `PIOC_ZERO;
    end else begin
      pu <= next_pu;
    end
  end

  // peripheral select: first offset clears, second sets
  always @* begin
    next_sel = setclr(sel, sel_second_d, sel_first_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sel <= `PIOC_ZERO;
    end else begin
      sel <= next_sel;
    end
  end

  // direct write mask
  always @* begin
    next_dw = setclr(dw, dw_set_d, dw_clr_d);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dw <= `PIOC_ZERO;
    end else begin
      dw <= next_dw;
    end
  end

  // pins are asynchronous: two flops before any logic reads them
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      sync1 <= `PIOC_ZERO;
      sync2 <= `PIOC_ZERO;
      sync3 <= `PIOC_ZERO;
    end else begin
      sync1 <= pin_i;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // a line counts as steady once two synced samples agree
  assign steady = ~(sync2 ^ sync3);

  // filter holds its level until the new one is seen twice; costs two cycles
  always @* begin
    next_filt = (steady & sync2) | (~steady & filt);
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      filt <= `PIOC_ZERO;
    end else begin
      filt <= next_filt;
    end
  end

  // history for change detection
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      prev <= `PIOC_ZERO;
      prev_ok <= 1'b0;
    end else begin
      prev <= level;
      prev_ok <= 1'b1;
    end
  end

  // deglitched lines read the filter, others the synced level
  assign level = ((dgl & filt) | (~dgl & sync2)) & wmask;
  // first sample after reset has no history, so no false change then
  assign change = prev_ok ? (level ^ prev) : `PIOC_ZERO;

  // set wins: a change in the clearing read cycle stays pending
  always @* begin
    if (pend_read) begin
      next_pend = change;
    end else begin
      next_pend = pend | change;
    end
  end

  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pend <= `PIOC_ZERO;
    end else begin
      pend <= next_pend;
    end
  end

  assign irq_o = |(pend & imask);

  // pin muxing
  assign own_eff = (own | ~LINE_MUXED) & wmask;
  assign mux_out = (sel & pb_out_i) | (~sel & pa_out_i);
  assign mux_oe = (sel & pb_oe_i) | (~sel & pa_oe_i);
  assign line_out = (own_eff & outd) | (~own_eff & mux_out);
  assign line_drive = ((own_eff & drv) | (~own_eff & mux_oe)) & wmask;
  // open drain lines only pull low; a high is left to the pull-up
  assign pin_o = line_out & ~od;
  assign pin_oe_n_o = ~(line_drive & (~od | ~line_out));
  assign pullup_o = pu;
  // peripherals see the unfiltered level
  assign periph_in_o = sync2;

  // read mux; write-only and reserved offsets read zero
  always @* begin
    if (rd_i) begin
      case (addr_i)
        `PIOC_OWN_STATE: next_rdata = own_eff;
        `PIOC_DRV_STATE: next_rdata = drv;
        `PIOC_DGL_STATE: next_rdata = dgl;
        `PIOC_OUT_STATE: next_rdata = outd;
        `PIOC_PIN_SAMPLE: next_rdata = level;
        `PIOC_IRQ_MASK: next_rdata = imask;
        `PIOC_IRQ_PEND: next_rdata = pend;
        `PIOC_OD_STATE: next_rdata = od;
        `PIOC_PU_STATE: next_rdata = pu;
        `PIOC_SEL_STATE: next_rdata = sel;
        `PIOC_DW_STATE: next_rdata = dw;
        default: next_rdata = `PIOC_ZERO;
      endcase
    end else begin
      next_rdata = `PIOC_ZERO;
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= `PIOC_ZERO;
    end else begin
      rdata_o <= next_rdata;
    end
  end

endmodule // pioc_top

// *** sim/pioc_chk.sv ***
// register port and pad checker of the parallel io controller
`timescale 1ns/10ps
`include "pioc_regs.vh"
module pioc_chk (
  // clock and reset
  input wire clock_i,
  input wire rst_i,
  // register port
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  // pins
  input wire [31:0] pin_oe_n_o,
  input wire [31:0] pullup_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
    else $error("read data without a read");
  AST_PU_SET: assert property (wr_i && addr_i == `PIOC_PU_SET |=>
    (pullup_o & $past(wdata_i)) == $past(wdata_i)) else $error("pull-up not set");
  AST_PU_CLR: assert property (wr_i && addr_i == `PIOC_PU_CLR |=>
    (pullup_o & $past(wdata_i)) == 32'h0) else $error("pull-up not cleared");
  AST_RSVD: assert property (rd_i && (addr_i == 8'h0c || addr_i == `PIOC_OWN_SET) |=>
    rdata_o == 32'h0) else $error("reserved or write-only read not zero");
  AST_OUT_SET: assert property (wr_i && addr_i == `PIOC_OUT_SET ##1
    rd_i && addr_i == `PIOC_OUT_STATE |=> (rdata_o & $past(wdata_i, 2)) == $past(wdata_i, 2))
    else $error("output level not set");
  AST_OUT_CLR: assert property (wr_i && addr_i == `PIOC_OUT_CLR ##1
    rd_i && addr_i == `PIOC_OUT_STATE |=> (rdata_o & $past(wdata_i, 2)) == 32'h0)
    else $error("output level not cleared");
  AST_SEL_B: assert property (wr_i && addr_i == `PIOC_SEL_SECOND ##1
    rd_i && addr_i == `PIOC_SEL_STATE |=> (rdata_o & $past(wdata_i, 2)) == $past(wdata_i, 2))
    else $error("second select not set");
  // owned line with drive cleared must be released
  AST_DRV_OFF: assert property (wr_i && addr_i == `PIOC_OWN_SET ##1 wr_i &&
    addr_i == `PIOC_DRV_CLR && wdata_i == $past(wdata_i) |=>
    (pin_oe_n_o & $past(wdata_i)) == $past(wdata_i)) else $error("line still driven");
endmodule // pioc_chk
bind pioc_top pioc_chk i_pioc_chk (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
  .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o));

// *** sim/pioc_far.sv ***
// pad model: controller drive wins, else the external driver sets the level
`timescale 1ns/10ps
module pioc_far (
  // from the controller
  input wire [31:0] pin_o,
  input wire [31:0] pin_oe_n_o,
  // external level and resulting pad
  input wire [31:0] ext_i,
  output wire [31:0] pin_i
);
  assign pin_i = (~pin_oe_n_o & pin_o) | (pin_oe_n_o & ext_i);
endmodule // pioc_far

// *** sim/tb.sv ***
// self-checking bench of the parallel io controller
`timescale 1ns/10ps
`include "pioc_regs.vh"
module tb;
  reg clock_i, rst_i, wr_i, rd_i;
  reg [7:0] addr_i;
  reg [31:0] wdata_i, pa_out_i, pa_oe_i, pb_out_i, pb_oe_i, ext, old, d;
  wire [31:0] rdata_o, pin_i, pin_o, pin_oe_n_o, pullup_o, periph_in_o;
  wire irq_o;
  integer err_count, cmp_count, k, i, s;
  reg [31:0] m [0:8];
  pioc_top i_pioc_top (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o), .pullup_o(pullup_o), .pa_out_i(pa_out_i), .pa_oe_i(pa_oe_i),
    .pb_out_i(pb_out_i), .pb_oe_i(pb_oe_i), .periph_in_o(periph_in_o), .irq_o(irq_o));
  pioc_far i_pioc_far (.pin_o(pin_o), .pin_oe_n_o(pin_oe_n_o), .ext_i(ext), .pin_i(pin_i));
  task chk(input string n, input [31:0] v, input [31:0] e);
    cmp_count = cmp_count + 1;
    if (v !== e) begin
      err_count = err_count + 1;
      $display("CHECK FAILED %0s exp %h seen %h", n, e, v);
    end
  endtask
  task wr(input [7:0] a, input [31:0] v);
    @(posedge clock_i);
    wr_i <= 1; rd_i <= 0; addr_i <= a; wdata_i <= v;
  endtask
  task rd(input [7:0] a, input [31:0] e, input [31:0] mk);
    @(posedge clock_i);
    wr_i <= 0; rd_i <= 1; addr_i <= a;
    @(posedge clock_i);
    rd_i <= 0;
    #1 chk("rdata", rdata_o & mk, e & mk);
  endtask
  task hold(input integer n);
    @(posedge clock_i);
    wr_i <= 0; rd_i <= 0;
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  function [7:0] base(input integer n);
    base = (n == 8) ? 8'ha0 : 8'(n * 16);
  endfunction
  task conclude;
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    clock_i = 0;
    forever #5 clock_i = ~clock_i;
  end
  // generous: the sequence needs about a thousand cycles
  initial begin
    #200000;
    err_count = err_count + 1;
    conclude;
  end
  initial begin
    err_count = 0; cmp_count = 0; rst_i = 1; wr_i = 0; rd_i = 0; addr_i = 0; wdata_i = 0;
    s = $urandom(1244);
    pa_out_i = $urandom; pa_oe_i = $urandom; pb_out_i = $urandom; pb_oe_i = $urandom;
    ext = 0;
    for (k = 0; k < 9; k = k + 1) m[k] = 0;
    repeat (12) @(posedge clock_i);
    rst_i <= 0;
    // every place but pin level and pending reads zero after reset
    for (k = 0; k < 64; k = k + 1) if (k != 15 && k != 19) rd(8'(k * 4), 0, '1);
    // pu and select use the lower offset to clear
    for (k = 0; k < 300; k = k + 1) begin
      i = $urandom % 9; d = $urandom;
      case ($urandom % 4)
        0: begin wr(base(i) + ((i == 6 || i == 7) ? 4 : 0), d); m[i] = m[i] | d; end
        1: begin wr(base(i) + ((i == 6 || i == 7) ? 0 : 4), d); m[i] = m[i] & ~d; end
        2: begin wr(`PIOC_OUT_STATE, d); m[3] = (m[3] & ~m[8]) | (d & m[8]); i = 3; end
        default: wr(8'h0c + 8'((i % 3) * 16), d);
      endcase
      rd(base(i) + 8, m[i], '1);
      if (i == 6) chk("pullup", pullup_o, m[6]);
    end
    wr(`PIOC_OWN_SET, '1);
    wr(`PIOC_DRV_CLR, '1);
    wr(`PIOC_IRQ_CLR, '1);
    hold(6);
    chk("oe_n", pin_oe_n_o, '1);
    rd(`PIOC_IRQ_PEND, 0, 0);
    old = ext; ext = $urandom | 32'h1;
    hold(6);
    chk("periph_in", periph_in_o, ext);
    rd(`PIOC_PIN_SAMPLE, ext, '1);
    chk("irq", {31'h0, irq_o}, 0);
    wr(`PIOC_IRQ_SET, '1);
    hold(1);
    chk("irq", {31'h0, irq_o}, 1);
    rd(`PIOC_IRQ_PEND, old ^ ext, '1);
    chk("irq", {31'h0, irq_o}, 0);
    rd(`PIOC_IRQ_PEND, 0, '1);
    conclude;
  end
endmodule // tb
